/* File: shared/act_pkg.sv */
// Constants and state types for the converter configuration and trim register bank.
// Assumes one system clock; serial pins are sampled by it.
package act_pkg;
   // Register offsets as seen by the host
   localparam logic [3:0] ACT_OFS_CONFIG = 4'h0;
   localparam logic [3:0] ACT_OFS_TRIM = 4'h2;
   // Select codes in word bits 15:12
   localparam int ACT_CODE_MSB = 15;
   localparam int ACT_CODE_LSB = 12;
   localparam logic [3:0] ACT_CODE_CFG_READ = 4'h3;
   localparam logic [3:0] ACT_CODE_CFG_WRITE = 4'h8;
   localparam logic [3:0] ACT_CODE_TRIM_A = 4'h9;
   localparam logic [3:0] ACT_CODE_TRIM_B = 4'ha;
   // Config word field positions
   localparam int ACT_BIT_LANE = 10;
   localparam int ACT_BIT_RANGE = 9;
   localparam int ACT_BIT_NEG_BIAS = 7;
   localparam int ACT_BIT_REF = 6;
   localparam int ACT_BIT_HOLD = 5;
   localparam int ACT_BIT_FORMAT = 4;
   localparam logic [11:0] ACT_CFG_WRITE_ONLY = 12'h020;
   // Trim field in word bits 11:3
   localparam int ACT_TRIM_MSB = 11;
   localparam int ACT_TRIM_LSB = 3;
   // Reset values
   localparam logic [11:0] ACT_CFG_RESET = 12'h000;
   localparam logic [8:0] ACT_TRIM_RESET = 9'h1ff;
   // Frame counts in serial clock falling edges
   localparam logic [5:0] ACT_FRAME_MIN_FALLS = 6'h30;
   localparam logic [5:0] ACT_WORD_BITS = 6'h10;

   typedef enum logic [1:0] {
      ACT_IDLE = 2'b01,
      ACT_FRAME = 2'b10
   } act_state_type;

   typedef struct packed {
      act_state_type state;
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_q;
      logic csn_s1;
      logic csn_s2;
      logic csn_q;
      logic sdi_s1;
      logic sdi_s2;
      logic [15:0] in_word;
      logic [5:0] falls;
      logic [11:0] cfg;
      logic [8:0] trim_a;
      logic [8:0] trim_b;
      logic hold;
      logic readback;
      logic [31:0] out_a;
      logic [15:0] out_b;
      logic oe;
   } act_regs_type;
endpackage

/* File: rtl/act_config_trim.sv */
// Configuration and reference trim register bank behind the serial frame pins.
// Assumes serial pins are asynchronous to i_clock and far slower than it.
`timescale 1ns/1ns

// Overview of operation
// - Word bits 15:12 are a select code; 0011 arms a config word readback.
// - Code 1000 loads word bits 11:0 into config; other codes leave it.
// - Lane select clear: result A on lane A, result B on lane B.
// - Lane select set: result A then result B on lane A alone.
// - Config bit 9 picks full-scale range, reference or twice it; reset zero.
// - Config bit 7 records negative input bias, ground or half range.
// - Config bit 6 picks external or internal reference; reset external.
// - Config bit 5 is write-only hold request; reset zero.
// - Config bit 4 picks straight binary or two's complement results.
// - Code 1001 writes the channel A trim register.
// - Trim field is used only for codes 1001 and 1010.
// - Trim bits 11:3 set reference level; default 1FF is highest.
// - A frame ended before 48 falling edges discards its write.
// - Valid write with hold bit set enters hold at select rising edge.
// - In hold with internal reference, reference stays powered, trims kept.
module act_config_trim (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Serial frame pins
   input wire logic i_sclk,
   input wire logic i_select_n,
   input wire logic i_serial_in,
   output logic o_serial_out_a,
   output logic o_serial_oe_a,
   output logic o_serial_out_b,
   output logic o_serial_oe_b,
   // Conversion results, straight binary
   input wire logic [15:0] i_result_a,
   input wire logic [15:0] i_result_b,
   // Configuration to the analog side
   output logic o_output_lane_select,
   output logic o_range_double,
   output logic o_neg_bias_half,
   output logic o_internal_ref,
   output logic o_twos_complement,
   output logic o_hold,
   output logic o_ref_powered,
   output logic [8:0] o_trim_a,
   output logic [8:0] o_trim_b
);
   import act_pkg::*;

   act_regs_type r_r;
   act_regs_type r_nxt;
   logic fall;
   logic cs_fall;
   logic cs_rise;
   logic end_ok;
   logic [3:0] code;

   // Straight binary to two's complement flips the sign bit
   function automatic logic [15:0] fmt(input logic [15:0] v, input logic twos);
      fmt = {v[15] ^ twos, v[14:0]};
   endfunction

   assign fall = r_r.sclk_q & ~r_r.sclk_s2;
   assign cs_fall = r_r.csn_q & ~r_r.csn_s2;
   assign cs_rise = ~r_r.csn_q & r_r.csn_s2;
   assign code = r_r.in_word[ACT_CODE_MSB:ACT_CODE_LSB];
   assign end_ok = (r_r.state == ACT_FRAME) && cs_rise && (r_r.falls >= ACT_FRAME_MIN_FALLS);

   always_comb begin
      r_nxt = r_r;
      r_nxt.sclk_s1 = i_sclk;
      r_nxt.sclk_s2 = r_r.sclk_s1;
      r_nxt.sclk_q = r_r.sclk_s2;
      r_nxt.csn_s1 = i_select_n;
      r_nxt.csn_s2 = r_r.csn_s1;
      r_nxt.csn_q = r_r.csn_s2;
      r_nxt.sdi_s1 = i_serial_in;
      r_nxt.sdi_s2 = r_r.sdi_s1;
      case (r_r.state)
         ACT_IDLE: begin
            if (cs_fall) begin
               r_nxt.state = ACT_FRAME;
               r_nxt.falls = '0;
               r_nxt.oe = 1'b1;
               r_nxt.readback = 1'b0;
               if (r_r.hold) begin
                  r_nxt.out_a = 32'hffff_ffff;
                  r_nxt.out_b = 16'hffff;
               end else if (r_r.readback) begin
                  // Write-only hold bit reads back as zero
                  r_nxt.out_a = {4'h0, r_r.cfg & ~ACT_CFG_WRITE_ONLY, 16'h0000};
                  r_nxt.out_b = 16'h0000;
               end else if (r_r.cfg[ACT_BIT_LANE]) begin
                  r_nxt.out_a = {fmt(i_result_a, r_r.cfg[ACT_BIT_FORMAT]),
                                 fmt(i_result_b, r_r.cfg[ACT_BIT_FORMAT])};
                  r_nxt.out_b = 16'h0000;
               end else begin
                  r_nxt.out_a = {fmt(i_result_a, r_r.cfg[ACT_BIT_FORMAT]), 16'h0000};
                  r_nxt.out_b = fmt(i_result_b, r_r.cfg[ACT_BIT_FORMAT]);
               end
            end
         end
         ACT_FRAME: begin
            if (cs_rise) begin
               r_nxt.state = ACT_IDLE;
               r_nxt.oe = 1'b0;
               // Short frames change nothing
               if (end_ok) begin
                  if (code == ACT_CODE_CFG_WRITE) begin
                     r_nxt.cfg = r_r.in_word[11:0];
                     r_nxt.hold = r_r.in_word[ACT_BIT_HOLD];
                  end else if (code == ACT_CODE_CFG_READ) begin
                     r_nxt.readback = 1'b1;
                  end else if (code == ACT_CODE_TRIM_A) begin
                     r_nxt.trim_a = r_r.in_word[ACT_TRIM_MSB:ACT_TRIM_LSB];
                  end else if (code == ACT_CODE_TRIM_B) begin
                     r_nxt.trim_b = r_r.in_word[ACT_TRIM_MSB:ACT_TRIM_LSB];
                  end
               end
            end else if (fall) begin
               if (r_r.falls < ACT_WORD_BITS) begin
                  r_nxt.in_word = {r_r.in_word[14:0], r_r.sdi_s2};
               end
               if (r_r.falls != ACT_FRAME_MIN_FALLS) begin
                  r_nxt.falls = r_r.falls + 6'h01;
               end
               r_nxt.out_a = {r_r.out_a[30:0], r_r.hold};
               r_nxt.out_b = {r_r.out_b[14:0], r_r.hold};
            end
         end
         default: begin
            r_nxt.state = ACT_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         r_r <= '0;
         r_r.state <= ACT_IDLE;
         r_r.sclk_s1 <= 1'b1;
         r_r.sclk_s2 <= 1'b1;
         r_r.sclk_q <= 1'b1;
         r_r.csn_s1 <= 1'b1;
         r_r.csn_s2 <= 1'b1;
         r_r.csn_q <= 1'b1;
         r_r.cfg <= ACT_CFG_RESET;
         r_r.trim_a <= ACT_TRIM_RESET;
         r_r.trim_b <= ACT_TRIM_RESET;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign o_serial_out_a = r_r.out_a[31];
   assign o_serial_oe_a = r_r.oe;
   assign o_serial_out_b = r_r.out_b[15];
   assign o_serial_oe_b = r_r.oe & ~r_r.cfg[ACT_BIT_LANE];
   assign o_output_lane_select = r_r.cfg[ACT_BIT_LANE];
   assign o_range_double = r_r.cfg[ACT_BIT_RANGE];
   assign o_neg_bias_half = r_r.cfg[ACT_BIT_NEG_BIAS];
   assign o_internal_ref = r_r.cfg[ACT_BIT_REF];
   assign o_twos_complement = r_r.cfg[ACT_BIT_FORMAT];
   assign o_hold = r_r.hold;
   // Trims are never cleared by hold
   assign o_ref_powered = ~r_r.hold | r_r.cfg[ACT_BIT_REF];
   assign o_trim_a = r_r.trim_a;
   assign o_trim_b = r_r.trim_b;

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   a_abort_keeps_cfg: assert property (
      ((r_r.state == ACT_FRAME) && cs_rise && (r_r.falls < ACT_FRAME_MIN_FALLS))
      |=> $stable(r_r.cfg) && $stable(r_r.trim_a) && $stable(r_r.trim_b) && !r_r.readback)
      else $error("aborted frame changed a register");
   a_cfg_write_load: assert property (
      (end_ok && code == ACT_CODE_CFG_WRITE) |=> (r_r.cfg == $past(r_r.in_word[11:0])))
      else $error("config write not loaded");
   a_cfg_other_code: assert property (
      (r_r.state == ACT_IDLE) && !$past(end_ok) |-> $stable(r_r.cfg))
      else $error("config changed outside a valid write");
   a_readback_arm: assert property (
      (end_ok && code == ACT_CODE_CFG_READ) |=> r_r.readback ##0 $stable(r_r.cfg))
      else $error("readback not armed");
   a_trim_a_write: assert property (
      (end_ok && code == ACT_CODE_TRIM_A) |=> (o_trim_a == $past(r_r.in_word[11:3])) && $stable(o_trim_b))
      else $error("channel A trim write wrong");
   a_trim_b_write: assert property (
      (end_ok && code == ACT_CODE_TRIM_B) |=> (o_trim_b == $past(r_r.in_word[11:3])) && $stable(o_trim_a))
      else $error("channel B trim write wrong");
   a_trim_ignored: assert property (
      !(end_ok && (code == ACT_CODE_TRIM_A || code == ACT_CODE_TRIM_B)) |=> $stable(r_r.trim_a) && $stable(r_r.trim_b))
      else $error("trim changed by other code");
   a_hold_entry: assert property (
      (end_ok && code == ACT_CODE_CFG_WRITE && r_r.in_word[ACT_BIT_HOLD]) |=> o_hold ##1 o_hold)
      else $error("hold not entered at frame end");
   a_hold_ref_kept: assert property (
      (o_hold && o_internal_ref) |-> o_ref_powered)
      else $error("internal reference dropped in hold");
   a_lane_single: assert property (
      (r_r.state == ACT_IDLE && cs_fall && !r_r.hold && !r_r.readback && r_r.cfg[ACT_BIT_LANE])
      |=> r_r.out_a == {fmt($past(i_result_a), r_r.cfg[ACT_BIT_FORMAT]), fmt($past(i_result_b), r_r.cfg[ACT_BIT_FORMAT])}
          && !o_serial_oe_b)
      else $error("single lane load wrong");
   a_lane_parallel: assert property (
      (r_r.state == ACT_IDLE && cs_fall && !r_r.hold && !r_r.readback && !r_r.cfg[ACT_BIT_LANE])
      |=> r_r.out_b == fmt($past(i_result_b), r_r.cfg[ACT_BIT_FORMAT]) && o_serial_oe_b)
      else $error("parallel lane load wrong");

   // Lane drivers follow the frame
   a_oe_frame_start: assert property (
      (r_r.state == ACT_IDLE && cs_fall)
      |=> o_serial_oe_a)
      else $error("lane A not driven in frame");
   a_oe_frame_end: assert property (
      (r_r.state == ACT_FRAME && cs_rise)
      |=> !o_serial_oe_a && !o_serial_oe_b)
      else $error("lane still driven after frame");
   a_idle_no_oe: assert property (
      (r_r.state == ACT_IDLE)
      |-> !o_serial_oe_a && !o_serial_oe_b)
      else $error("lane driven while idle");
   a_state_onehot: assert property (
      $onehot(r_r.state))
      else $error("frame state not one-hot");

   // Frame start contents
   a_hold_ones: assert property (
      (r_r.state == ACT_IDLE && cs_fall && r_r.hold)
      |=> (r_r.out_a == 32'hffff_ffff) && (r_r.out_b == 16'hffff))
      else $error("hold frame not all ones");
   a_readback_data: assert property (
      (r_r.state == ACT_IDLE && cs_fall && !r_r.hold && r_r.readback)
      |=> r_r.out_a == {4'h0, r_r.cfg & ~ACT_CFG_WRITE_ONLY, 16'h0000})
      else $error("readback word wrong");
   a_readback_once: assert property (
      (r_r.state == ACT_IDLE && cs_fall)
      |=> !r_r.readback)
      else $error("readback left armed");
   a_format_sign: assert property (
      (r_r.state == ACT_IDLE && cs_fall && !r_r.hold && !r_r.readback && !r_r.cfg[ACT_BIT_LANE])
      |=> r_r.out_a[31:16] == {$past(i_result_a[15]) ^ r_r.cfg[ACT_BIT_FORMAT], $past(i_result_a[14:0])})
      else $error("result coding wrong");

   // Shifting inside a frame
   a_shift_a: assert property (
      (r_r.state == ACT_FRAME && !cs_rise && fall)
      |=> r_r.out_a == {$past(r_r.out_a[30:0]), $past(r_r.hold)})
      else $error("lane A shift wrong");
   a_word_shift: assert property (
      (r_r.state == ACT_FRAME && !cs_rise && fall && (r_r.falls < ACT_WORD_BITS))
      |=> r_r.in_word == {$past(r_r.in_word[14:0]), $past(r_r.sdi_s2)})
      else $error("input word shift wrong");
   a_falls_limit: assert property (
      r_r.falls <= ACT_FRAME_MIN_FALLS)
      else $error("fall count past limit");

   // Hold state changes only at valid frame ends
   a_hold_exit: assert property (
      (end_ok && code == ACT_CODE_CFG_WRITE && !r_r.in_word[ACT_BIT_HOLD])
      |=> !o_hold)
      else $error("hold not left on clear");
   a_hold_stable: assert property (
      !end_ok
      |=> $stable(r_r.hold))
      else $error("hold changed outside valid write");
   a_short_no_hold: assert property (
      ((r_r.state == ACT_FRAME) && cs_rise && (r_r.falls < ACT_FRAME_MIN_FALLS))
      |=> $stable(r_r.hold))
      else $error("aborted frame changed hold");
   a_trim_kept_hold: assert property (
      (o_hold && o_internal_ref && !end_ok)
      |=> $stable(o_trim_a) && $stable(o_trim_b))
      else $error("trim lost in hold");
endmodule

/* File: tb/act_host_model.sv */
// Host model that drives serial frames into the register bank pins.
// Assumes a free-running bench; link clock period 125 ns, idle high between frames.
`timescale 1ns/1ns
module act_host_model (
   // Serial frame pins
   output logic o_sclk,
   output logic o_select_n,
   output logic o_serial_in,
   input wire logic i_serial_out_a,
   input wire logic i_serial_out_b
);
   logic [47:0] lane_a;
   logic [47:0] lane_b;
   initial begin
      o_sclk = 1'b1;
      o_select_n = 1'b1;
      o_serial_in = 1'b0;
      lane_a = '0;
      lane_b = '0;
   end
   // Word MSB first, zeros after it; fewer than 48 falls aborts
   task automatic frame(input logic [15:0] word, input int falls);
      logic [15:0] sh;
      sh = word;
      o_select_n = 1'b0;
      for (int i = 0; i < falls; i++) begin
         o_serial_in = sh[15];
         sh = sh << 1;
         #62;
         lane_a = {lane_a[46:0], i_serial_out_a};
         lane_b = {lane_b[46:0], i_serial_out_b};
         o_sclk = 1'b0;
         #63;
         o_sclk = 1'b1;
      end
      lane_a = lane_a << (48 - falls);
      lane_b = lane_b << (48 - falls);
      #62;
      o_select_n = 1'b1;
      // Released line shows the inverse of its last level
      o_serial_in = ~o_serial_in;
      #300;
   endtask
endmodule

/* File: tb/tb_act_config_trim.sv */
// Self-checking bench for the configuration and trim register bank.
// Assumes the host model drives the serial clock, select and data-in pins; results are held steady.
`timescale 1ns/1ns
module tb_act_config_trim;
   import act_pkg::*;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic sclk, select_n, serial_in, out_a, oe_a, out_b, oe_b;
   logic [15:0] result_a = 16'h1234;
   logic [15:0] result_b = 16'habcd;
   logic lane, rng, nbias, iref, twos, hold, refp;
   logic [8:0] trim_a, trim_b;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   always #5 i_clock = ~i_clock;

   act_config_trim act_config_trim_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_sclk(sclk),
      .i_select_n(select_n), .i_serial_in(serial_in), .o_serial_out_a(out_a), .o_serial_oe_a(oe_a),
      .o_serial_out_b(out_b), .o_serial_oe_b(oe_b), .i_result_a(result_a), .i_result_b(result_b),
      .o_output_lane_select(lane), .o_range_double(rng), .o_neg_bias_half(nbias),
      .o_internal_ref(iref), .o_twos_complement(twos), .o_hold(hold), .o_ref_powered(refp),
      .o_trim_a(trim_a), .o_trim_b(trim_b));

   act_host_model act_host_model_inst (.o_sclk(sclk), .o_select_n(select_n), .o_serial_in(serial_in),
      .i_serial_out_a(out_a), .i_serial_out_b(out_b));

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Expected configuration outputs for a stored word and hold state
   function automatic logic [6:0] cfg_exp(input logic [11:0] c, input logic h);
      return {c[ACT_BIT_LANE], c[ACT_BIT_RANGE], c[ACT_BIT_NEG_BIAS], c[ACT_BIT_REF],
         c[ACT_BIT_FORMAT], h, !h | c[ACT_BIT_REF]};
   endfunction

   function automatic logic [6:0] outs();
      return {lane, rng, nbias, iref, twos, hold, refp};
   endfunction

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (16) @(posedge i_clock);
      #1 i_nrst = 1'b1;
      repeat (8) @(posedge i_clock);
      check(outs(), cfg_exp(ACT_CFG_RESET, 1'b0));
      check({trim_a, trim_b}, {ACT_TRIM_RESET, ACT_TRIM_RESET});
      act_host_model_inst.frame(16'h86d0, 48);
      check(act_host_model_inst.lane_a, {16'h1234, 32'h0});
      check(act_host_model_inst.lane_b, {16'habcd, 32'h0});
      check({oe_a, oe_b}, 2'b00);
      check(outs(), cfg_exp(12'h6d0, 1'b0));
      check({trim_a, trim_b}, {9'h1ff, 9'h1ff});
      act_host_model_inst.frame(16'h3000, 48);
      check(act_host_model_inst.lane_a, {16'h9234, 16'h2bcd, 16'h0});
      check(outs(), cfg_exp(12'h6d0, 1'b0));
      act_host_model_inst.frame(16'h0000, 48);
      check(act_host_model_inst.lane_a[47:32], 16'h06d0);
      check(outs(), cfg_exp(12'h6d0, 1'b0));
      act_host_model_inst.frame(16'h95d0, 48);
      check({trim_a, trim_b}, {9'h0ba, 9'h1ff});
      act_host_model_inst.frame(16'ha918, 48);
      check({trim_a, trim_b}, {9'h0ba, 9'h123});
      act_host_model_inst.frame(16'h9008, 20);
      check({trim_a, trim_b}, {9'h0ba, 9'h123});
      act_host_model_inst.frame(16'h8020, 48);
      check(outs(), cfg_exp(12'h020, 1'b1));
      act_host_model_inst.frame(16'h8060, 48);
      check({act_host_model_inst.lane_a[47:32], act_host_model_inst.lane_b[47:32]}, 32'hffff_ffff);
      check(outs(), cfg_exp(12'h060, 1'b1));
      check({trim_a, trim_b}, {9'h0ba, 9'h123});
      act_host_model_inst.frame(16'h8000, 48);
      check(outs(), cfg_exp(12'h000, 1'b0));
      give_verdict();
   end
endmodule
